// File: bench/ifm_cpu_model.sv
`timescale 1ns/100ps
// cpu side: takes a pending request after a set wait and notes the vector
module ifm_cpu_model (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       irq_req_q,
    input wire logic       irq_enable_q,
    input wire logic [3:0] irq_vector_q,
    input wire logic       ack_on,
    input wire logic [3:0] ack_delay,
    output     logic       irq_accept,
    output     logic [3:0] vector_seen
);
    logic [3:0] wait_q;
    // takes only while enabled, so one request gives one pulse
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_accept  <= 1'b0;
            wait_q      <= 4'h0;
            vector_seen <= 4'h0;
        end
        else
        begin
            irq_accept <= 1'b0;
            wait_q     <= (ack_on && irq_req_q && irq_enable_q) ? wait_q + 4'h1 : 4'h0;
            if (ack_on && irq_req_q && irq_enable_q && !irq_accept && wait_q == ack_delay)
            begin
                irq_accept  <= 1'b1;
                vector_seen <= irq_vector_q;
                wait_q      <= 4'h0;
            end
        end
    end
endmodule : ifm_cpu_model

// File: bench/ifm_irq_props.sv
`timescale 1ns/100ps
// port-level checks of the interrupt flag and mask unit
module ifm_irq_props (
    input wire logic                  clk_sys,
    input wire logic                  rst_b,
    input wire ifm_pkg::ifm_reg_req_t reg_req,
    input wire logic [3:0]            rd_data_q,
    input wire ifm_pkg::ifm_ticks_t   ticks,
    input wire logic [3:0]            port_group_pins,
    input wire logic                  single_input_pin,
    input wire logic                  global_irq_on,
    input wire logic                  global_irq_off,
    input wire logic                  irq_accept,
    input wire logic                  irq_enable_q,
    input wire logic                  irq_req_q,
    input wire logic [3:0]            irq_vector_q,
    input wire logic                  cpu_wake_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // flag word reads; the quiet one has no time base event beside it
    sequence s_rd_tmr; reg_req.rd && reg_req.addr == ifm_pkg::OFS_TMR_FLAGS; endsequence
    sequence s_rd_psw; reg_req.rd && reg_req.addr == ifm_pkg::OFS_PSW_FLAGS; endsequence
    sequence s_quiet_tmr; s_rd_tmr ##0 ticks == '0; endsequence
    // time base flags set whatever the masks hold
    property p_fast; ticks.timer_fast_tick ##1 !reg_req.rd ##1 s_rd_tmr |=> rd_data_q[0]; endproperty
    a_fast: assert property (p_fast) else $error("fast tick flag lost");
    property p_half; ticks.timer_half_second ##1 !reg_req.rd ##1 s_rd_tmr |=> rd_data_q[2]; endproperty
    a_half: assert property (p_half) else $error("half second flag lost");
    property p_sw; ticks.stopwatch_second ##1 !reg_req.rd ##1 s_rd_psw |=> rd_data_q[1]; endproperty
    a_sw: assert property (p_sw) else $error("stopwatch flag lost");
    // a read empties the word, so a second quiet read sees zero
    property p_clear; s_quiet_tmr ##1 (ticks == '0) ##1 s_quiet_tmr |=> rd_data_q == 4'h0; endproperty
    a_clear: assert property (p_clear) else $error("flag kept after read");
    property p_d3; s_rd_tmr |=> !rd_data_q[3]; endproperty
    a_d3: assert property (p_d3) else $error("unused timer bit set");
    // request side: enable, take, vector and wake
    property p_on; global_irq_on && !global_irq_off && !irq_accept |=> irq_enable_q; endproperty
    a_on: assert property (p_on) else $error("enable not taken");
    property p_take; irq_accept |=> !irq_enable_q ##1 !irq_req_q; endproperty
    a_take: assert property (p_take) else $error("enable kept after take");
    property p_vec; irq_req_q |-> irq_vector_q != 4'h0; endproperty
    a_vec: assert property (p_vec) else $error("request without vector");
    property p_wake; cpu_wake_q == irq_req_q; endproperty
    a_wake: assert property (p_wake) else $error("wake differs from request");
endmodule : ifm_irq_props

bind ifm_irq_unit ifm_irq_props i_ifm_irq_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .rd_data_q(rd_data_q), .ticks(ticks),
    .port_group_pins(port_group_pins), .single_input_pin(single_input_pin),
    .global_irq_on(global_irq_on), .global_irq_off(global_irq_off), .irq_accept(irq_accept),
    .irq_enable_q(irq_enable_q), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .cpu_wake_q(cpu_wake_q));

// File: bench/tb.sv
`timescale 1ns/100ps
// register-level tests of the interrupt flag and mask unit
module tb;
    localparam logic [6:0] TMR = ifm_pkg::OFS_TMR_FLAGS;
    localparam logic [6:0] PSW = ifm_pkg::OFS_PSW_FLAGS;
    localparam logic [6:0] GMK = ifm_pkg::OFS_GRP_MASK;
    localparam int         FLT = 4;
    logic                  clk_sys = 1'b0;
    logic                  rst_b = 1'b0;
    ifm_pkg::ifm_reg_req_t reg_req = '0;
    ifm_pkg::ifm_ticks_t   ticks = '0;
    logic [3:0]            pins = 4'h0;
    logic                  s_pin = 1'b0;
    logic                  irq_on = 1'b0;
    logic                  irq_off = 1'b0;
    logic                  ack_on = 1'b0;
    logic [3:0]            ack_delay = 4'h0;
    logic                  irq_accept, irq_enable_q, irq_req_q, cpu_wake_q;
    logic [3:0]            rd_data_q, irq_vector_q, vector_seen;
    logic [6:0]            ofs [8] = '{7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h79, 7'h7a, 7'h10};
    int                    num_errors = 0;
    int                    checks_done = 0;
    int                    n;
    always #2.5 clk_sys = ~clk_sys;
    ifm_irq_unit #(.FILTER_CYCLES(FLT), .FILTER_ON(1'b1)) i_ifm_irq_unit (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .rd_data_q(rd_data_q), .ticks(ticks),
        .port_group_pins(pins), .single_input_pin(s_pin), .global_irq_on(irq_on),
        .global_irq_off(irq_off), .irq_accept(irq_accept), .irq_enable_q(irq_enable_q),
        .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q), .cpu_wake_q(cpu_wake_q));
    ifm_cpu_model i_ifm_cpu_model (
        .clk_sys(clk_sys), .rst_b(rst_b), .irq_req_q(irq_req_q), .irq_enable_q(irq_enable_q),
        .irq_vector_q(irq_vector_q), .ack_on(ack_on), .ack_delay(ack_delay),
        .irq_accept(irq_accept), .vector_seen(vector_seen));
    // bus, pin and pulse helpers; strobes drop one edge after rising
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input logic [3:0] exp);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 check(rd_data_q, exp);
    endtask : rd_chk
    task automatic tick(input ifm_pkg::ifm_ticks_t t);
        @(posedge clk_sys);
        ticks <= t;
        @(posedge clk_sys);
        ticks <= '0;
    endtask : tick
    task automatic pulse_en(input logic on);
        @(posedge clk_sys);
        irq_on  <= on;
        irq_off <= !on;
        @(posedge clk_sys);
        irq_on  <= 1'b0;
        irq_off <= 1'b0;
    endtask : pulse_en
    task automatic set_pins(input logic [3:0] g, input logic s);
        @(posedge clk_sys);
        pins  <= g;
        s_pin <= s;
        repeat (FLT) @(posedge clk_sys); // let the input filter pass the new level
    endtask : set_pins
    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : idle
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // a hang counts as a failure well past the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (ofs[i]) rd_chk(ofs[i], 4'h0);
        check(irq_req_q, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            tick(5'(1 << i));
            rd_chk(i < 2 ? PSW : TMR, 4'(1 << (i < 2 ? i : i - 2)));
            rd_chk(i < 2 ? PSW : TMR, 4'h0);
        end
        wr(TMR, 4'hf);
        rd_chk(TMR, 4'h0);
        $display("test time base flags done");
        // prompt and slow takes of a timer and a stopwatch request
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_sys);
            ack_delay <= k ? 4'h5 : 4'h0;
            wr(k ? ifm_pkg::OFS_SW_MASK : ifm_pkg::OFS_TMR_MASK, k ? 4'h2 : 4'h4);
            pulse_en(1'b1);
            tick(k ? 5'h02 : 5'h10);
            idle(2);
            check(irq_req_q, 1'b1);
            check(cpu_wake_q, 1'b1);
            check(irq_vector_q, k ? 4'h8 : 4'h4);
            @(posedge clk_sys);
            ack_on <= 1'b1;
            for (n = 0; n < 30 && irq_accept !== 1'b1; n++) idle(1);
            check(irq_accept, 1'b1);
            idle(2);
            check(irq_enable_q, 1'b0);
            check(vector_seen, k ? 4'h8 : 4'h4);
            @(posedge clk_sys);
            ack_on <= 1'b0;
            rd_chk(k ? PSW : TMR, k ? 4'h2 : 4'h4);
            wr(k ? ifm_pkg::OFS_SW_MASK : ifm_pkg::OFS_TMR_MASK, 4'h0);
        end
        $display("test request done");
        // pin edges: masked, rising, falling, mask rewritten while active
        set_pins(4'h1, 1'b0);
        rd_chk(PSW, 4'h0);
        set_pins(4'h0, 1'b0);
        wr(GMK, 4'h1);
        @(posedge clk_sys);
        pins <= 4'h1;
        repeat (FLT - 1) @(posedge clk_sys);
        pins <= 4'h0;
        rd_chk(PSW, 4'h0);
        set_pins(4'h1, 1'b0);
        rd_chk(PSW, 4'h4);
        set_pins(4'h0, 1'b0);
        rd_chk(PSW, 4'h0);
        wr(GMK, 4'h0);
        wr(ifm_pkg::OFS_GRP_EDGE, 4'h1);
        set_pins(4'h1, 1'b0);
        wr(GMK, 4'h1);
        rd_chk(ifm_pkg::OFS_GRP_EDGE, 4'h1);
        set_pins(4'h0, 1'b0);
        rd_chk(PSW, 4'h4);
        wr(GMK, 4'h0);
        wr(GMK, 4'h1);
        rd_chk(PSW, 4'h4);
        wr(GMK, 4'h0);
        wr(ifm_pkg::OFS_SINGLE, 4'h4);
        pulse_en(1'b1);
        set_pins(4'h0, 1'b1);
        idle(2);
        check(irq_vector_q, 4'h1);
        rd_chk(ifm_pkg::OFS_SINGLE, 4'h5);
        rd_chk(PSW, 4'h8);
        pulse_en(1'b0);
        idle(1);
        check(irq_enable_q, 1'b0);
        $display("test pins done");
        complete_run();
    end
endmodule : tb

// File: hw/ifm_edge_detect.sv
`timescale 1ns/100ps
// gated edge finder: fires when mask and active level first coincide
module ifm_edge_detect (
    clk_sys,
    rst_b,
    pin,
    edge_sel,
    mask,
    hit
);
    input  wire logic clk_sys;
    input  wire logic rst_b;
    input  wire logic pin;
    input  wire logic edge_sel;
    input  wire logic mask;
    output      logic hit;

    typedef struct packed {
        logic armed;
    } ifm_edge_state_t;

    ifm_edge_state_t s_q;
    ifm_edge_state_t s_d;
    logic            active;

    // edge_sel one means falling, so the active level is low
    always_comb
    begin
        active   = mask & (pin ^ edge_sel);
        s_d      = s_q;
        s_d.armed = active;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // mask set or edge_sel flipped while active also fires, as a pin edge would
    assign hit = active & ~s_q.armed;

endmodule : ifm_edge_detect

// File: hw/ifm_irq_unit.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// (R1) timer flag word: D2 half second, D1 eighth second, D0 fast tick.
// (R2) second flag word: D3 single pin, D2 pin group, D1/D0 stopwatch.
// (R3) flags clear when read; no write path reaches them.
// (R4) reset clears flags, masks and edge selects, all sources masked.
// (R5) one mask per pin: group word, single pin at D2.
// (R6) edge select per pin: group word, single pin at D1.
// (R7) an input flag cannot set while that pin's mask is zero.
// (R8) timer and stopwatch flags set regardless of their masks.
// (R9) flag set with mask one and global enable raises a request.
// (R10) optional input filter may delay an input flag up to 1 ms.
// (R11) mask cleared then set while pin active sets the flag again.
// (R12) software re-enables an input mask only with the pin inactive.
// (R13) edge select rewritten while masked on and active may set the flag.
// (R14) a clock timer reset may set a timer flag spuriously.
// (R15) edge select one picks falling edge, zero picks rising edge.
// (R16) accepting an interrupt clears the global enable.
// (R17) vector low bits: stopwatch, timer, pin group, single pin.
// (R18) a request wakes the halted core.
// (R19) unused D3 of the timer flag word reads zero, ignores access.
module ifm_irq_unit #(
    parameter int FILTER_CYCLES = ifm_pkg::FILTER_CYCLES,
    parameter bit FILTER_ON     = 1'b0
) (
    clk_sys,
    rst_b,
    reg_req,
    rd_data_q,
    ticks,
    port_group_pins,
    single_input_pin,
    global_irq_on,
    global_irq_off,
    irq_accept,
    irq_enable_q,
    irq_req_q,
    irq_vector_q,
    cpu_wake_q
);
    input  wire logic                 clk_sys;
    input  wire logic                 rst_b;
    input  wire ifm_pkg::ifm_reg_req_t reg_req;
    output      logic [3:0]           rd_data_q;
    input  wire ifm_pkg::ifm_ticks_t  ticks;
    input  wire logic [3:0]           port_group_pins;
    input  wire logic                 single_input_pin;
    input  wire logic                 global_irq_on;
    input  wire logic                 global_irq_off;
    input  wire logic                 irq_accept;
    output      logic                 irq_enable_q;
    output      logic                 irq_req_q;
    output      logic [3:0]           irq_vector_q;
    output      logic                 cpu_wake_q;

    // state of the unit except the pin filters and edge finders, registered as one word
    typedef struct packed {
        logic [3:0] port_group_edge_select;
        logic [3:0] port_group_pin_masks;
        logic [1:0] stopwatch_masks;
        logic       single_pin_mask;
        logic       single_pin_edge_select;
        logic [2:0] timer_masks;
        logic [2:0] timer_flags;
        logic [3:0] port_sw_flags;
        logic       irq_en;
        logic [3:0] rdata;
        logic       irq;
        logic [3:0] vector;
        logic       wake;
    } ifm_unit_state_t;

    ifm_unit_state_t s_q;
    ifm_unit_state_t s_d;

    logic [4:0] pins_raw;
    logic [4:0] pins_flt;
    logic [4:0] pin_edge_sel;
    logic [4:0] pin_mask;
    logic [4:0] pin_hit;
    logic [3:0] pend;
    logic       grp_hit;
    logic       single_hit;

    // bit 4 is the single pin, bits 3..0 the pin group
    assign pins_raw     = {single_input_pin, port_group_pins};
    assign pin_edge_sel = {s_q.single_pin_edge_select, s_q.port_group_edge_select};
    assign pin_mask     = {s_q.single_pin_mask, s_q.port_group_pin_masks};

    // per-pin filter and gated edge finder
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_pin
            ifm_noise_filter #(
                .CYCLES (FILTER_CYCLES),
                .ENABLE (FILTER_ON)
            ) u_flt (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .pin_in  (pins_raw[g]),
                .pin_out (pins_flt[g])
            ); // [R10]
            ifm_edge_detect u_edge (
                .clk_sys  (clk_sys),
                .rst_b    (rst_b),
                .pin      (pins_flt[g]),
                .edge_sel (pin_edge_sel[g]),
                .mask     (pin_mask[g]),
                .hit      (pin_hit[g])
            ); // [R7] [R11] [R13] [R15]
        end
    endgenerate

    assign grp_hit    = |pin_hit[3:0];
    assign single_hit = pin_hit[4];

    // next state: writes, read-clear, event sets, then the request
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = ifm_pkg::RST_NIBBLE;
        pend      = 4'h0;

        // register writes; flag words take no write
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                ifm_pkg::OFS_GRP_EDGE:
                    s_d.port_group_edge_select = reg_req.wdata; // [R6]
                ifm_pkg::OFS_GRP_MASK:
                    s_d.port_group_pin_masks = reg_req.wdata; // [R5]
                ifm_pkg::OFS_SW_MASK:
                    s_d.stopwatch_masks = reg_req.wdata[1:0];
                ifm_pkg::OFS_SINGLE:
                begin
                    s_d.single_pin_mask        = reg_req.wdata[ifm_pkg::BIT_S_MASK]; // [R5]
                    s_d.single_pin_edge_select = reg_req.wdata[ifm_pkg::BIT_S_EDGE]; // [R6]
                end
                ifm_pkg::OFS_TMR_MASK:
                    s_d.timer_masks = reg_req.wdata[2:0];
                default:
                    s_d.irq_en = s_q.irq_en; // flags and unmapped: ignored [R3] [R19]
            endcase
        end

        // reads return the word next cycle; flag words clear on read
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                ifm_pkg::OFS_GRP_EDGE:
                    s_d.rdata = s_q.port_group_edge_select;
                ifm_pkg::OFS_GRP_MASK:
                    s_d.rdata = s_q.port_group_pin_masks;
                ifm_pkg::OFS_SW_MASK:
                    s_d.rdata = {2'h0, s_q.stopwatch_masks};
                ifm_pkg::OFS_SINGLE:
                begin
                    s_d.rdata[ifm_pkg::BIT_S_MASK] = s_q.single_pin_mask;
                    s_d.rdata[ifm_pkg::BIT_S_EDGE] = s_q.single_pin_edge_select;
                    s_d.rdata[ifm_pkg::BIT_S_PIN]  = single_input_pin;
                end
                ifm_pkg::OFS_TMR_MASK:
                    s_d.rdata = {1'b0, s_q.timer_masks};
                ifm_pkg::OFS_TMR_FLAGS:
                begin
                    s_d.rdata       = {1'b0, s_q.timer_flags}; // [R1] [R19]
                    s_d.timer_flags = 3'h0; // [R3]
                end
                ifm_pkg::OFS_PSW_FLAGS:
                begin
                    s_d.rdata         = s_q.port_sw_flags; // [R2]
                    s_d.port_sw_flags = 4'h0; // [R3]
                end
                default:
                    s_d.rdata = ifm_pkg::RST_NIBBLE;
            endcase
        end

        // events set after the clear so a same-cycle event is kept
        // timer ticks set flags with no mask gating; a tick caused by a
        // timer reset is indistinguishable and sets its flag too
        if (ticks.timer_half_second)
            s_d.timer_flags[ifm_pkg::BIT_TMR_HALF] = 1'b1; // [R8] [R14]
        if (ticks.timer_eighth_second)
            s_d.timer_flags[ifm_pkg::BIT_TMR_EIGHT] = 1'b1; // [R8] [R14]
        if (ticks.timer_fast_tick)
            s_d.timer_flags[ifm_pkg::BIT_TMR_FAST] = 1'b1; // [R8] [R14]
        if (ticks.stopwatch_second)
            s_d.port_sw_flags[ifm_pkg::BIT_SW_SECOND] = 1'b1; // [R8]
        if (ticks.stopwatch_tenth)
            s_d.port_sw_flags[ifm_pkg::BIT_SW_TENTH] = 1'b1; // [R8]

        // input hits already carry their mask gating
        if (grp_hit)
            s_d.port_sw_flags[ifm_pkg::BIT_PORT_GRP] = 1'b1; // [R7]
        if (single_hit)
            s_d.port_sw_flags[ifm_pkg::BIT_SINGLE] = 1'b1; // [R7]

        // global enable: accept and disable win over enable
        if (irq_accept || global_irq_off)
            s_d.irq_en = 1'b0; // [R16]
        else if (global_irq_on)
            s_d.irq_en = 1'b1;

        // pending enabled groups, ordered as the vector bits
        pend[3] = |(s_d.port_sw_flags[1:0] & s_d.stopwatch_masks);
        pend[2] = |(s_d.timer_flags & s_d.timer_masks);
        pend[1] = s_d.port_sw_flags[ifm_pkg::BIT_PORT_GRP] & (|s_d.port_group_pin_masks);
        pend[0] = s_d.port_sw_flags[ifm_pkg::BIT_SINGLE] & s_d.single_pin_mask;

        // request follows the flag in the same edge that sets it
        s_d.irq    = s_d.irq_en & (|pend); // [R9]
        s_d.vector = pend; // [R17]
        s_d.wake   = s_d.irq; // [R18]
    end

    // single register for all state outside the pin filters and edge finders; reset leaves every source masked
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0; // [R4]
        else
            s_q <= s_d;
    end

    // outputs straight from the state register
    assign rd_data_q    = s_q.rdata;
    assign irq_enable_q = s_q.irq_en;
    assign irq_req_q    = s_q.irq;
    assign irq_vector_q = s_q.vector;
    assign cpu_wake_q   = s_q.wake;

endmodule : ifm_irq_unit

// File: hw/ifm_noise_filter.sv
`timescale 1ns/100ps
// passes a pin level on only after it has stood for CYCLES clocks
module ifm_noise_filter #(
    parameter int CYCLES = 200000,
    parameter bit ENABLE = 1'b0
) (
    clk_sys,
    rst_b,
    pin_in,
    pin_out
);
    input  wire logic clk_sys;
    input  wire logic rst_b;
    input  wire logic pin_in;
    output      logic pin_out;

    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic          level;
        logic [CW-1:0] cnt;
    } ifm_flt_state_t;

    ifm_flt_state_t s_q;
    ifm_flt_state_t s_d;

    // a level differing from the held one must last the whole window
    always_comb
    begin
        s_d = s_q;
        if (pin_in == s_q.level)
            s_d.cnt = '0;
        else if (s_q.cnt == CW'(CYCLES - 1))
        begin
            s_d.level = pin_in;
            s_d.cnt   = '0;
        end
        else
            s_d.cnt = s_q.cnt + CW'(1);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // bypass keeps the edge latency at one cycle when unused
    assign pin_out = ENABLE ? s_q.level : pin_in;

endmodule : ifm_noise_filter

// File: include/ifm_pkg.sv
package ifm_pkg;

    // nibble-wide register port, seven address bits
    localparam int ADDR_W = 7;
    localparam int DATA_W = 4;

    // register offsets
    localparam logic [6:0] OFS_GRP_EDGE  = 7'h74;
    localparam logic [6:0] OFS_GRP_MASK  = 7'h75;
    localparam logic [6:0] OFS_SW_MASK   = 7'h76;
    localparam logic [6:0] OFS_SINGLE    = 7'h77;
    localparam logic [6:0] OFS_TMR_MASK  = 7'h78;
    localparam logic [6:0] OFS_TMR_FLAGS = 7'h79;
    localparam logic [6:0] OFS_PSW_FLAGS = 7'h7a;

    // field positions
    localparam int BIT_TMR_FAST  = 0;
    localparam int BIT_TMR_EIGHT = 1;
    localparam int BIT_TMR_HALF  = 2;
    localparam int BIT_SW_TENTH  = 0;
    localparam int BIT_SW_SECOND = 1;
    localparam int BIT_PORT_GRP  = 2;
    localparam int BIT_SINGLE    = 3;
    localparam int BIT_S_PIN     = 0;
    localparam int BIT_S_EDGE    = 1;
    localparam int BIT_S_MASK    = 2;

    // reset values
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic       RST_BIT    = 1'b0;

    // noise filter: longest delay 1 ms at a 5 ns clock
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int FILTER_DELAY_US = 1000;
    localparam int FILTER_CYCLES   = (FILTER_DELAY_US * 1000000) / CLK_PERIOD_PS;

    // register request from the cpu side
    typedef struct packed {
        logic [6:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } ifm_reg_req_t;

    // timing events, one-cycle pulses from the time bases
    typedef struct packed {
        logic timer_half_second;
        logic timer_eighth_second;
        logic timer_fast_tick;
        logic stopwatch_second;
        logic stopwatch_tenth;
    } ifm_ticks_t;

endpackage : ifm_pkg
